// File: inc/tcc_cfg.svh
// register map, field positions, reset values and mode codes of the timer
// assumes the including file uses the values as plain text substitutions
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

`define TCC_A_CTRL0      4'h0
`define TCC_A_CTRL1      4'h1
`define TCC_A_IOC0       4'h2
`define TCC_A_IOC1       4'h3
`define TCC_A_IOC2       4'h4
`define TCC_A_OPT0       4'h5
`define TCC_A_CCR0       4'h6
`define TCC_A_CCR1       4'h7
`define TCC_A_CNT        4'h8

`define TCC_CNT_IDLE     16'hffff
`define TCC_CNT_MAX      16'hffff
`define TCC_CNT_ZERO     16'h0000
`define TCC_CNT_STEP     16'h0001
`define TCC_WORD_RST     16'h0000

`define TCC_MD_INTERVAL  3'h0
`define TCC_MD_EVENT     3'h1
`define TCC_MD_EXTTRIG   3'h2
`define TCC_MD_ONESHOT   3'h3
`define TCC_MD_PWM       3'h4
`define TCC_MD_FREERUN   3'h5
`define TCC_MD_PULSEW    3'h6

`define TCC_B_RUN        0
`define TCC_F_MODE       2:0
`define TCC_B_EXTCLK     5
`define TCC_B_SWTRIG     6
`define TCC_F_OUTEN      1:0
`define TCC_F_CAP0       1:0
`define TCC_F_CAP1       3:2
`define TCC_F_TRIG       1:0
`define TCC_F_EVT        3:2
`define TCC_B_OVF        0
`define TCC_F_CCS        5:4
`define TCC_F_EDGES      3:0

`define TCC_EDGE_RISE    2'h1
`define TCC_EDGE_FALL    2'h2
`define TCC_EDGE_BOTH    2'h3

`endif

// File: inc/tcc_pkg.sv
// types and mode decoding shared by the timer modules
// assumes tcc_cfg.svh is on the include path
`include "tcc_cfg.svh"

package tcc_pkg;

   typedef logic [15:0] tcc_word_t;
   typedef logic [2:0]  tcc_mode_t;

   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_arm  = 3'b010,
      st_run  = 3'b100
   } tcc_state_e;

   function automatic logic tcc_is_batch(input tcc_mode_t m);
      tcc_is_batch = (m == `TCC_MD_EXTTRIG) || (m == `TCC_MD_PWM);
   endfunction

   function automatic logic tcc_is_trig(input tcc_mode_t m);
      tcc_is_trig = (m == `TCC_MD_EXTTRIG) || (m == `TCC_MD_ONESHOT);
   endfunction

   function automatic logic tcc_is_ovf(input tcc_mode_t m);
      tcc_is_ovf = (m == `TCC_MD_FREERUN) || (m == `TCC_MD_PULSEW);
   endfunction

   function automatic logic tcc_clears(input tcc_mode_t m);
      tcc_clears = !tcc_is_ovf(m);
   endfunction

endpackage

// File: inc/tcc_core_if.sv
// signals between the timer core, its edge detectors and its channels
// assumes one instance inside the timer top
`timescale 1ns/10ps
`default_nettype none

interface tcc_core_if;
   import tcc_pkg::*;

   logic [1:0]       pin;
   logic [1:0]       cap_sel0;
   logic [1:0]       cap_sel1;
   logic [1:0]       trig_sel;
   logic [1:0]       evt_sel;
   logic [1:0]       cap_edge;
   logic             trig_edge;
   logic             evt_edge;
   logic [1:0]       wr;
   logic [1:0]       cap;
   tcc_word_t        wdata;
   tcc_word_t        count;
   logic             load;
   logic             anytime;
   logic [1:0][15:0] ccr;
   logic [1:0][15:0] cbuf;

   modport edet (input pin, cap_sel0, cap_sel1, trig_sel, evt_sel,
                 output cap_edge, trig_edge, evt_edge);
   modport chan (input wr, cap, wdata, count, load, anytime,
                 output ccr, cbuf);
   modport core (output pin, cap_sel0, cap_sel1, trig_sel, evt_sel,
                 output wr, cap, wdata, count, load, anytime,
                 input cap_edge, trig_edge, evt_edge, ccr, cbuf);

endinterface

`default_nettype wire

// File: logic/tcc_edge_det.sv
// valid-edge detection on both capture pins for capture, and on pin 0 only for trigger and event
// assumes pin levels are already synchronous to i_clock
`timescale 1ns/10ps
`default_nettype none
`include "tcc_cfg.svh"

module tcc_edge_det (
   // clock and reset
   input  wire logic  i_clock,
   input  wire logic  i_rst,
   // core side
   tcc_core_if.edet   io_core
);
   import tcc_pkg::*;

   logic [1:0] prev_r;
   logic [1:0] prev_nxt;

   // select code 00 never fires, so capture is off by default
   function automatic logic edge_hit(input logic [1:0] sel, input logic was,
                                     input logic now);
      case (sel)
         `TCC_EDGE_RISE: edge_hit = !was && now;
         `TCC_EDGE_FALL: edge_hit = was && !now;
         `TCC_EDGE_BOTH: edge_hit = was != now;
         default:        edge_hit = 1'h0;
      endcase
   endfunction

   always_comb begin
      prev_nxt = io_core.pin;
      io_core.cap_edge[0] = edge_hit(io_core.cap_sel0, prev_r[0], io_core.pin[0]);
      io_core.cap_edge[1] = edge_hit(io_core.cap_sel1, prev_r[1], io_core.pin[1]);
      io_core.trig_edge   = edge_hit(io_core.trig_sel, prev_r[0], io_core.pin[0]);
      io_core.evt_edge    = edge_hit(io_core.evt_sel, prev_r[0], io_core.pin[0]);
   end

   // a pin already high at reset release looks like a rising edge
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         prev_r <= '0;
      end else begin
         prev_r <= prev_nxt;
      end
   end

endmodule

`default_nettype wire

// File: logic/tcc_chan.sv
// both capture/compare registers and their compare buffers
// assumes the core gates writes and captures by mode
`timescale 1ns/10ps
`default_nettype none
`include "tcc_cfg.svh"

module tcc_chan (
   // clock and reset
   input  wire logic  i_clock,
   input  wire logic  i_rst,
   // core side
   tcc_core_if.chan   io_core
);
   import tcc_pkg::*;

   logic [1:0][15:0] ccr_r;
   logic [1:0][15:0] ccr_nxt;
   logic [1:0][15:0] buf_r;
   logic [1:0][15:0] buf_nxt;

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         // capture beats a write in the same cycle
         if (io_core.cap[i]) begin
            ccr_nxt[i] = io_core.count;
         end else if (io_core.wr[i]) begin
            ccr_nxt[i] = io_core.wdata;
         end else begin
            ccr_nxt[i] = ccr_r[i];
         end
         if (io_core.load) begin
            buf_nxt[i] = io_core.wr[i] ? io_core.wdata : ccr_r[i];
         end else if (io_core.anytime && io_core.wr[i]) begin
            buf_nxt[i] = io_core.wdata;
         end else begin
            buf_nxt[i] = buf_r[i];
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ccr_r <= {2{`TCC_WORD_RST}};
         buf_r <= {2{`TCC_WORD_RST}};
      end else begin
         ccr_r <= ccr_nxt;
         buf_r <= buf_nxt;
      end
   end

   assign io_core.ccr  = ccr_r;
   assign io_core.cbuf = buf_r;

endmodule

`default_nettype wire

// File: logic/tcc_timer16.sv
// 16-bit timer with two capture/compare channels, register port and pins
// assumes capture pins synchronous to i_clock; count clock is i_clock or event edges
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "tcc_cfg.svh"

module tcc_timer16 (
   // clock and reset
   input  wire logic            i_clock,
   input  wire logic            i_rst,
   // register port
   input  wire logic [3:0]      i_addr,
   input  wire tcc_pkg::tcc_word_t i_wdata,
   input  wire logic            i_wr,
   input  wire logic            i_rd,
   output logic [15:0]          o_rdata,
   // pins
   input  wire logic            i_capture_input_0,
   input  wire logic            i_capture_input_1,
   output logic                 o_toggle_output_0,
   output logic                 o_toggle_output_1,
   // interrupt requests
   output logic                 o_compare_irq_0,
   output logic                 o_compare_irq_1,
   output logic                 o_overflow_irq
);
   import tcc_pkg::*;

   tcc_core_if core ();

   logic       run_enable_bit_r;
   logic       run_enable_bit_nxt;
   tcc_mode_t  mode_select_field_r;
   tcc_mode_t  mode_select_field_nxt;
   logic       external_clock_enable_r;
   logic       external_clock_enable_nxt;
   logic [1:0] outen_r;
   logic [1:0] outen_nxt;
   logic [3:0] capsel_r;
   logic [3:0] capsel_nxt;
   logic [3:0] ioc2_r;
   logic [3:0] ioc2_nxt;
   logic [1:0] capture_select_r;
   logic [1:0] capture_select_nxt;
   logic       overflow_flag_r;
   logic       overflow_flag_nxt;
   tcc_word_t  rdata_r;
   tcc_word_t  rdata_nxt;

   tcc_state_e state_r;
   tcc_state_e state_nxt;
   tcc_word_t  cnt_r;
   tcc_word_t  cnt_nxt;
   logic [1:0] out_r;
   logic [1:0] out_nxt;
   logic       irq0_r;
   logic       irq0_nxt;
   logic       irq1_r;
   logic       irq1_nxt;
   logic       ovirq_r;
   logic       ovirq_nxt;

   logic       sw_trig;
   logic       trig;
   logic       tick;
   logic       running;
   logic       ch0_cmp;
   logic       ch1_cmp;
   logic       hit0;
   logic       hit1;
   logic       load_c;
   logic       ovf_set;
   logic       is_pw;
   logic       is_fr;

   tcc_edge_det u_edet (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .io_core (core.edet)
   );

   tcc_chan u_chan (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .io_core (core.chan)
   );

   // mode decode and request qualification
   assign is_pw   = mode_select_field_r == `TCC_MD_PULSEW;
   assign is_fr   = mode_select_field_r == `TCC_MD_FREERUN;
   assign ch0_cmp = !is_pw && !(is_fr && capture_select_r[0]);
   assign ch1_cmp = !is_pw && !(is_fr && capture_select_r[1]);
   assign running = (state_r == st_run) && run_enable_bit_r;
   assign sw_trig = i_wr && (i_addr == `TCC_A_CTRL1) && i_wdata[`TCC_B_SWTRIG];
   // trigger sources do nothing outside the two triggered modes
   assign trig    = tcc_is_trig(mode_select_field_r) && (sw_trig || core.trig_edge);
   assign tick    = (external_clock_enable_r || (mode_select_field_r == `TCC_MD_EVENT)) ?
                    core.evt_edge : 1'h1;
   assign hit0    = cnt_r == core.cbuf[0];
   assign hit1    = cnt_r == core.cbuf[1];

   assign core.pin      = {i_capture_input_1, i_capture_input_0};
   assign core.cap_sel0 = capsel_r[`TCC_F_CAP0];
   assign core.cap_sel1 = capsel_r[`TCC_F_CAP1];
   assign core.trig_sel = ioc2_r[`TCC_F_TRIG];
   assign core.evt_sel  = ioc2_r[`TCC_F_EVT];
   assign core.cap[0]   = running && !ch0_cmp && core.cap_edge[0];
   assign core.cap[1]   = running && !ch1_cmp && core.cap_edge[1];
   // writes in pulse-width mode are dropped: those registers only capture
   assign core.wr[0]    = i_wr && (i_addr == `TCC_A_CCR0) && !is_pw;
   assign core.wr[1]    = i_wr && (i_addr == `TCC_A_CCR1) && !is_pw;
   assign core.wdata    = i_wdata;
   assign core.count    = cnt_r;
   assign core.anytime  = !tcc_is_batch(mode_select_field_r);
   assign core.load     = load_c;

   // register port: writes and registered read data
   always_comb begin
      run_enable_bit_nxt        = run_enable_bit_r;
      mode_select_field_nxt     = mode_select_field_r;
      external_clock_enable_nxt = external_clock_enable_r;
      outen_nxt                 = outen_r;
      capsel_nxt                = capsel_r;
      ioc2_nxt                  = ioc2_r;
      capture_select_nxt        = capture_select_r;
      if (i_wr) begin
         case (i_addr)
            `TCC_A_CTRL0: run_enable_bit_nxt = i_wdata[`TCC_B_RUN];
            `TCC_A_CTRL1: begin
               mode_select_field_nxt     = i_wdata[`TCC_F_MODE];
               external_clock_enable_nxt = i_wdata[`TCC_B_EXTCLK];
            end
            `TCC_A_IOC0: outen_nxt = i_wdata[`TCC_F_OUTEN];
            `TCC_A_IOC1: capsel_nxt = i_wdata[`TCC_F_EDGES];
            `TCC_A_IOC2: ioc2_nxt = i_wdata[`TCC_F_EDGES];
            `TCC_A_OPT0: capture_select_nxt = i_wdata[`TCC_F_CCS];
            default: ;
         endcase
      end
      rdata_nxt = `TCC_WORD_RST;
      if (i_rd) begin
         case (i_addr)
            `TCC_A_CTRL0: rdata_nxt[`TCC_B_RUN] = run_enable_bit_r;
            `TCC_A_CTRL1: begin
               rdata_nxt[`TCC_F_MODE]   = mode_select_field_r;
               rdata_nxt[`TCC_B_EXTCLK] = external_clock_enable_r;
            end
            `TCC_A_IOC0: rdata_nxt[`TCC_F_OUTEN] = outen_r;
            `TCC_A_IOC1: rdata_nxt[`TCC_F_EDGES] = capsel_r;
            `TCC_A_IOC2: rdata_nxt[`TCC_F_EDGES] = ioc2_r;
            `TCC_A_OPT0: begin
               rdata_nxt[`TCC_B_OVF] = overflow_flag_r;
               rdata_nxt[`TCC_F_CCS] = capture_select_r;
            end
            // the whole word is sampled in one edge, so a capture cannot tear it
            `TCC_A_CCR0: rdata_nxt = core.ccr[0];
            `TCC_A_CCR1: rdata_nxt = core.ccr[1];
            `TCC_A_CNT: rdata_nxt = run_enable_bit_r ? cnt_r : `TCC_CNT_ZERO;
            default: rdata_nxt = `TCC_WORD_RST;
         endcase
      end
   end

   // counter, outputs and interrupt pulses
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      out_nxt   = out_r;
      load_c    = 1'h0;
      irq0_nxt  = 1'h0;
      irq1_nxt  = 1'h0;
      ovirq_nxt = 1'h0;
      ovf_set   = 1'h0;
      case (state_r)
         st_idle: begin
            cnt_nxt = `TCC_CNT_IDLE;
            out_nxt = '0;
            if (run_enable_bit_r) begin
               state_nxt = st_arm;
            end
         end
         st_arm: begin
            if (!run_enable_bit_r) begin
               state_nxt = st_idle;
            end else if (tick && (trig || !tcc_is_trig(mode_select_field_r))) begin
               cnt_nxt   = `TCC_CNT_ZERO;
               load_c    = 1'h1;
               state_nxt = st_run;
               if (outen_r[0]) begin
                  out_nxt[0] = !out_r[0];
               end
            end
         end
         st_run: begin
            if (!run_enable_bit_r) begin
               state_nxt = st_idle;
               cnt_nxt   = `TCC_CNT_IDLE;
            end else if (trig) begin
               cnt_nxt = `TCC_CNT_ZERO;
               load_c  = 1'h1;
            end else if (is_pw && (|core.cap)) begin
               cnt_nxt = `TCC_CNT_ZERO;
            end else if (tick) begin
               if (ch0_cmp && hit0) begin
                  irq0_nxt = 1'h1;
                  if (outen_r[0]) begin
                     out_nxt[0] = !out_r[0];
                  end
               end
               if (ch1_cmp && hit1) begin
                  irq1_nxt = 1'h1;
                  if (outen_r[1]) begin
                     out_nxt[1] = !out_r[1];
                  end
               end
               // clearing on the match makes the period value plus one ticks
               if (ch0_cmp && hit0 && tcc_clears(mode_select_field_r)) begin
                  cnt_nxt = `TCC_CNT_ZERO;
                  load_c  = tcc_is_batch(mode_select_field_r);
                  if (mode_select_field_r == `TCC_MD_ONESHOT) begin
                     state_nxt = st_arm;
                     cnt_nxt   = `TCC_CNT_IDLE;
                  end
               end else begin
                  cnt_nxt = cnt_r + `TCC_CNT_STEP;
                  if ((cnt_r == `TCC_CNT_MAX) && tcc_is_ovf(mode_select_field_r)) begin
                     ovf_set   = 1'h1;
                     ovirq_nxt = 1'h1;
                  end
               end
            end
         end
         default: state_nxt = st_idle;
      endcase
      // a wrap in the clearing cycle still sets the flag
      if (ovf_set) begin
         overflow_flag_nxt = 1'h1;
      end else if (!run_enable_bit_r ||
                   (i_wr && (i_addr == `TCC_A_OPT0) && !i_wdata[`TCC_B_OVF])) begin
         overflow_flag_nxt = 1'h0;
      end else begin
         overflow_flag_nxt = overflow_flag_r;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         run_enable_bit_r        <= 1'h0;
         mode_select_field_r     <= `TCC_MD_INTERVAL;
         external_clock_enable_r <= 1'h0;
         outen_r                 <= '0;
         capsel_r                <= '0;
         ioc2_r                  <= '0;
         capture_select_r        <= '0;
         overflow_flag_r         <= 1'h0;
         rdata_r                 <= `TCC_WORD_RST;
         state_r                 <= st_idle;
         cnt_r                   <= `TCC_CNT_IDLE;
         out_r                   <= '0;
         irq0_r                  <= 1'h0;
         irq1_r                  <= 1'h0;
         ovirq_r                 <= 1'h0;
      end else begin
         run_enable_bit_r        <= run_enable_bit_nxt;
         mode_select_field_r     <= mode_select_field_nxt;
         external_clock_enable_r <= external_clock_enable_nxt;
         outen_r                 <= outen_nxt;
         capsel_r                <= capsel_nxt;
         ioc2_r                  <= ioc2_nxt;
         capture_select_r        <= capture_select_nxt;
         overflow_flag_r         <= overflow_flag_nxt;
         rdata_r                 <= rdata_nxt;
         state_r                 <= state_nxt;
         cnt_r                   <= cnt_nxt;
         out_r                   <= out_nxt;
         irq0_r                  <= irq0_nxt;
         irq1_r                  <= irq1_nxt;
         ovirq_r                 <= ovirq_nxt;
      end
   end

   assign o_rdata           = rdata_r;
   assign o_toggle_output_0 = out_r[0];
   assign o_toggle_output_1 = out_r[1];
   assign o_compare_irq_0   = irq0_r;
   assign o_compare_irq_1   = irq1_r;
   assign o_overflow_irq    = ovirq_r;

   // checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   sequence s_start;
      (state_r == st_arm) ##1 (state_r == st_run);
   endsequence

   sequence s_interval_hit;
      running && (mode_select_field_r == `TCC_MD_INTERVAL) && tick && hit0;
   endsequence

   cap0_store_a: assert property (running && is_fr && capture_select_r[0] && core.cap_edge[0]
      |=> core.ccr[0] == $past(cnt_r)) else $error("channel 0 capture lost");
   pw_clear_a: assert property (running && is_pw && core.cap_edge[0]
      |=> (cnt_r == `TCC_CNT_ZERO) && (core.ccr[0] == $past(cnt_r)))
      else $error("pulse-width capture 0 wrong");
   read_coherent_a: assert property (i_rd && (i_addr == `TCC_A_CCR1)
      |=> o_rdata == $past(core.ccr[1])) else $error("channel 1 read torn");
   cap1_store_a: assert property (running && is_fr && capture_select_r[1] && core.cap_edge[1]
      |=> core.ccr[1] == $past(cnt_r)) else $error("channel 1 capture lost");
   pw_clear1_a: assert property (running && is_pw && core.cap_edge[1]
      |=> cnt_r == `TCC_CNT_ZERO) else $error("pulse-width capture 1 no clear");
   rd_count_a: assert property (i_rd && (i_addr == `TCC_A_CNT) && run_enable_bit_r
      |=> o_rdata == $past(cnt_r)) else $error("counter readback wrong");
   rd_idle_a: assert property (i_rd && (i_addr == `TCC_A_CNT) && !run_enable_bit_r
      |=> o_rdata == `TCC_CNT_ZERO) else $error("stopped readback not zero");
   start_clear_a: assert property (s_start |-> cnt_r == `TCC_CNT_ZERO)
      else $error("start did not clear counter");
   interval_hit_a: assert property ((s_interval_hit and !core.wr[0])
      |=> (cnt_r == `TCC_CNT_ZERO) && o_compare_irq_0) else $error("interval match");
   half_wave_a: assert property ((s_interval_hit and outen_r[0])
      |=> o_toggle_output_0 != $past(o_toggle_output_0)) else $error("output 0 no toggle");
   ovf_set_a: assert property (running && is_fr && tick && (cnt_r == `TCC_CNT_MAX)
      |=> overflow_flag_r && o_overflow_irq) else $error("wrap not flagged");
   no_ovf_a: assert property ((mode_select_field_r == `TCC_MD_INTERVAL) ##1
      (mode_select_field_r == `TCC_MD_INTERVAL) |-> !o_overflow_irq)
      else $error("overflow irq in interval mode");
   batch_hold_a: assert property (tcc_is_batch(mode_select_field_r) && core.wr[1] && !load_c
      |=> core.cbuf[1] == $past(core.cbuf[1])) else $error("batch write leaked");

endmodule

`default_nettype wire

// File: sim/tcc_pin_model.sv
// partner model of the two capture pins: each request toggles one pin level
// assumes requests are one-cycle pulses set just after a rising edge
`timescale 1ns/10ps
`default_nettype none

module tcc_pin_model (
   // clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   // requests and pins
   input  wire logic [1:0] i_flip,
   output logic [1:0]      o_pin
);
   // pins idle low; a level change lands just after an edge, like a synchronous source
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst)
         o_pin <= 2'h0;
      else
         o_pin <= o_pin ^ i_flip;
   end
endmodule

`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench: register port, interval, capture, event count, pulse width
// assumes tcc_cfg.svh on the include path and the pin model beside the timer
`timescale 1ns/10ps
`default_nettype none
`include "tcc_cfg.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end

module tb_top;
   logic        i_clock = 1'b0;
   logic        i_rst   = 1'b1;
   logic        i_wr    = 1'b0;
   logic        i_rd    = 1'b0;
   logic [3:0]  i_addr  = 4'h0;
   logic [15:0] i_wdata = 16'h0000;
   logic [1:0]  flip    = 2'h0;
   logic [1:0]  pin;
   logic [15:0] o_rdata;
   logic        out0, out1, irq0, irq1, ovf;
   int          miscompares = 0;
   int          tests_run   = 0;

   tcc_pin_model PINS (.i_clock(i_clock), .i_rst(i_rst), .i_flip(flip), .o_pin(pin));
   tcc_timer16 DUT (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_capture_input_0(pin[0]),
      .i_capture_input_1(pin[1]), .o_toggle_output_0(out0), .o_toggle_output_1(out1),
      .o_compare_irq_0(irq0), .o_compare_irq_1(irq1), .o_overflow_irq(ovf));

   initial begin
      forever #10 i_clock = ~i_clock;
   end

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clock);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clock);
      i_wr    <= 1'b0;
   endtask

   // data stands only in the cycle after the strobe is taken
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge i_clock);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clock);
      i_rd   <= 1'b0;
      #1 v = o_rdata;
   endtask

   task automatic wait_irq0;
      int n;
      for (n = 0; n < 64 && irq0 !== 1'b1; n++) begin
         @(posedge i_clock);
         #1;
      end
      if (n == 64) begin
         miscompares++;
         $display("Error at %0t: compare pulse never came", $time);
         report_and_stop();
      end
   endtask

   task automatic t_reset;
      logic [15:0] v;
      rd(`TCC_A_CNT, v);
      `CHK(v, 16'h0000)
      rd(`TCC_A_CCR1, v);
      `CHK(v, 16'h0000)
      wr(`TCC_A_CNT, 16'hffff);
      rd(`TCC_A_CNT, v);
      `CHK(v, 16'h0000)
      rd(4'hf, v);
      `CHK(v, 16'h0000)
   endtask

   // period 3+1 cycles; channel 1 below channel 0 fires once a period
   task automatic t_interval;
      logic [15:0] v;
      logic        o, o1, s1, so;
      int          n;
      wr(`TCC_A_CCR0, 16'h0003);
      wr(`TCC_A_CCR1, 16'h0001);
      wr(`TCC_A_IOC0, 16'h0003);
      wr(`TCC_A_CTRL0, 16'h0001);
      wait_irq0();
      o  = out0;
      o1 = out1;
      s1 = 1'b0;
      so = 1'b0;
      n  = 0;
      do begin
         @(posedge i_clock);
         #1 n++;
         s1 |= irq1;
         so |= ovf;
      end while (irq0 !== 1'b1 && n < 20);
      `CHK(n, 4)
      `CHK(out0, ~o)
      `CHK(s1, 1'b1)
      `CHK(out1, ~o1)
      `CHK(so, 1'b0)
      // a write that reached the counter would push it far past the period
      wr(`TCC_A_CNT, 16'hfff0);
      rd(`TCC_A_CNT, v);
      `CHK(v <= 16'h0003, 1'b1)
      wr(`TCC_A_CTRL0, 16'h0000);
      rd(`TCC_A_CNT, v);
      `CHK(v, 16'h0000)
   endtask

   // rising edges 7 cycles apart: the two captures differ by 7
   task automatic t_capture;
      logic [15:0] c0, c1;
      wr(`TCC_A_CTRL1, 16'h0005);
      wr(`TCC_A_OPT0, 16'h0030);
      wr(`TCC_A_IOC1, 16'h0005);
      wr(`TCC_A_CTRL0, 16'h0001);
      repeat (4) @(posedge i_clock);
      flip <= 2'h1;
      @(posedge i_clock);
      flip <= 2'h0;
      repeat (6) @(posedge i_clock);
      flip <= 2'h2;
      @(posedge i_clock);
      flip <= 2'h0;
      repeat (3) @(posedge i_clock);
      rd(`TCC_A_CCR0, c0);
      rd(`TCC_A_CCR1, c1);
      `CHK(c0 !== 16'h0000, 1'b1)
      `CHK(c1 - c0, 16'h0007)
   endtask

   // event count, both edges: first edge starts, then ccr0+1 edges per compare pulse
   task automatic t_event;
      logic s;
      wr(`TCC_A_CTRL0, 16'h0000);
      wr(`TCC_A_IOC1, 16'h0000);
      wr(`TCC_A_IOC2, 16'h000c);
      wr(`TCC_A_CTRL1, 16'h0001);
      wr(`TCC_A_CCR0, 16'h0001);
      wr(`TCC_A_CTRL0, 16'h0001);
      for (int k = 1; k <= 3; k++) begin
         s = 1'b0;
         @(posedge i_clock);
         flip <= 2'h1;
         @(posedge i_clock);
         flip <= 2'h0;
         repeat (4) begin
            @(posedge i_clock);
            #1 s |= irq0;
         end
         `CHK(s, k == 3)
      end
   endtask

   // pulse width: input 0 clears the counter, input 1 six cycles later stores 5
   task automatic t_pwidth;
      logic [15:0] v;
      wr(`TCC_A_CTRL0, 16'h0000);
      wr(`TCC_A_CTRL1, 16'h0006);
      wr(`TCC_A_IOC1, 16'h000f);
      wr(`TCC_A_CTRL0, 16'h0001);
      repeat (2) @(posedge i_clock);
      flip <= 2'h1;
      @(posedge i_clock);
      flip <= 2'h0;
      repeat (5) @(posedge i_clock);
      flip <= 2'h2;
      @(posedge i_clock);
      flip <= 2'h0;
      repeat (2) @(posedge i_clock);
      rd(`TCC_A_CCR1, v);
      `CHK(v, 16'h0005)
   endtask

   initial begin
      repeat (10) @(posedge i_clock);
      i_rst <= 1'b0;
      t_reset();
      t_interval();
      t_capture();
      t_event();
      t_pwidth();
      report_and_stop();
   end
endmodule

`default_nettype wire
